//--- core/spi_client_port.sv
/*
  Client end of the serial link: decodes command frames and masters the
  internal bus for single-byte reads and writes.
  Assumes link pins are asynchronous to clk_sys and the sclk is slow enough
  for a three-cycle sampling delay.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_client_port #(
  parameter int EN_CYC = spi_link_pkg::T_SPI_EN_CYC,
  parameter int BUS_WAIT = spi_link_pkg::BUS_WAIT_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  spi_link_if.device link,
  // chip control
  input wire logic powerup_enable_pin,
  input wire logic stop_mode,
  input wire logic [1:0] security_level_field,
  // software register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic link_enable_bit,
  // internal bus master
  output logic bus_req,
  input wire logic bus_gnt,
  output logic [15:0] bus_addr,
  output logic [7:0] bus_wdata,
  output logic bus_we,
  output logic bus_re,
  input wire logic [7:0] bus_rdata,
  output logic cpu_stall
);

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_REQ = 4'b0010,
    S_ACC = 4'b0100,
    S_DONE = 4'b1000
  } bus_state_t;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] sync1, sync2, prev, next_sync2, next_prev;
  logic [15:0] in_shift, out_shift, next_in_shift, next_out_shift;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic miso_out, miso_oe, next_miso_out, next_miso_oe;
  logic in_frame, next_in_frame;
  logic [13:0] resp_body, next_resp_body;
  logic awaiting_wr, next_awaiting_wr;
  logic [12:0] wr_addr, next_wr_addr;
  logic [15:0] pu_cnt, next_pu_cnt;
  logic pu_window, next_pu_window;
  logic next_link_enable_bit;
  logic [7:0] next_reg_rdata;
  bus_state_t state, next_state;
  logic op_we, next_op_we;
  logic [12:0] op_addr, next_op_addr;
  logic [7:0] op_data, next_op_data;
  logic [7:0] wait_cnt, next_wait_cnt;
  logic next_bus_req, next_bus_we, next_bus_re, next_cpu_stall;
  logic [15:0] next_bus_addr;
  logic [7:0] next_bus_wdata;

  logic sclk_rise, sclk_fall, ss_fall, ss_rise, mosi_s, pin_s, secured;

  assign link.miso_out = miso_out;
  assign link.miso_oe = miso_oe;
  assign sclk_rise = sync2[2] & ~prev[2];
  assign sclk_fall = ~sync2[2] & prev[2];
  assign ss_fall = ~sync2[1] & prev[1];
  assign ss_rise = sync2[1] & ~prev[1];
  assign mosi_s = sync2[0];
  assign pin_s = sync2[3];
  assign secured = security_level_field != spi_link_pkg::SECURE_OPEN;

  function automatic logic addr_ok(input logic [12:0] a, input logic locked);
    return !locked || (a <= spi_link_pkg::SECURE_LO_END) ||
           ((a >= spi_link_pkg::SECURE_HI_START) && (a <= spi_link_pkg::SECURE_HI_END));
  endfunction : addr_ok

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [4:0] st;
    logic clk_bad, par_bad, start_op, start_we;
    logic [12:0] a;
    logic [7:0] start_data;
    st = spi_link_pkg::ST_OK;
    clk_bad = 1'b0;
    par_bad = 1'b0;
    start_op = 1'b0;
    start_we = 1'b0;
    a = in_shift[spi_link_pkg::A_HI:spi_link_pkg::A_LO];
    start_data = in_shift[spi_link_pkg::D_HI:spi_link_pkg::D_LO];
    next_sync2 = sync1;
    next_prev = sync2;
    next_in_shift = in_shift;
    next_out_shift = out_shift;
    next_bit_cnt = bit_cnt;
    next_miso_out = miso_out;
    next_miso_oe = miso_oe;
    next_in_frame = in_frame;
    next_resp_body = resp_body;
    next_awaiting_wr = awaiting_wr;
    next_wr_addr = wr_addr;
    next_pu_cnt = pu_cnt;
    next_pu_window = pu_window;
    next_link_enable_bit = link_enable_bit;
    next_reg_rdata = 8'h00;
    next_state = state;
    next_op_we = op_we;
    next_op_addr = op_addr;
    next_op_data = op_data;
    next_wait_cnt = wait_cnt;
    next_bus_req = bus_req;
    next_bus_we = 1'b0;
    next_bus_re = 1'b0;
    next_bus_addr = bus_addr;
    next_bus_wdata = bus_wdata;
    next_cpu_stall = cpu_stall;

    // software enable register
    if (reg_rd && reg_addr == spi_link_pkg::ENABLE_REG_ADDR) begin
      next_reg_rdata[spi_link_pkg::ENABLE_BIT] = link_enable_bit;
    end
    if (reg_wr && reg_addr == spi_link_pkg::ENABLE_REG_ADDR) begin
      next_link_enable_bit = reg_wdata[spi_link_pkg::ENABLE_BIT];
    end
    // power-up enable window: EN_CYC low pin cycles set the enable and close it; the first high pin level closes it earlier
    if (pu_window) begin
      if (!pin_s) begin
        next_pu_cnt = pu_cnt + 16'h0001;
        if (pu_cnt == 16'(EN_CYC - 1)) begin
          next_link_enable_bit = 1'b1;
          next_pu_window = 1'b0;
        end
      end else begin
        next_pu_window = 1'b0;
      end
    end

    // frame start: present the pending response msb first
    if (ss_fall && link_enable_bit && !stop_mode) begin
      next_in_frame = 1'b1;
      next_bit_cnt = 5'h00;
      next_out_shift = {resp_body, spi_link_pkg::frame_parity(resp_body)};
      next_miso_out = resp_body[13];
      next_miso_oe = 1'b1;
    end else if (in_frame) begin
      if (sclk_rise) begin
        next_in_shift = {in_shift[14:0], mosi_s};
        if (bit_cnt != spi_link_pkg::CNT_SAT) begin
          next_bit_cnt = bit_cnt + 5'h01;
        end
      end
      if (sclk_fall) begin
        next_out_shift = {out_shift[14:0], 1'b0};
        next_miso_out = out_shift[14];
      end
      if (ss_rise) begin
        next_in_frame = 1'b0;
        next_miso_oe = 1'b0;
        clk_bad = bit_cnt != spi_link_pkg::CNT_FULL;
        par_bad = spi_link_pkg::frame_parity(in_shift[15:2]) !=
                  in_shift[spi_link_pkg::P_HI:spi_link_pkg::P_LO];
        if (state == S_IDLE) begin
          if (clk_bad || par_bad) begin
            st[spi_link_pkg::ST_CLK] = clk_bad;
            st[spi_link_pkg::ST_PAR] = par_bad;
            st[spi_link_pkg::ST_IGN] = 1'b1;
            next_awaiting_wr = 1'b0;
            next_resp_body = {resp_body[13], st, resp_body[7:0]};
          end else if (awaiting_wr) begin
            next_awaiting_wr = 1'b0;
            a = wr_addr;
            if (in_shift[spi_link_pkg::B_RW]) begin
              start_op = 1'b1;
              start_we = 1'b1;
            end else begin
              st[spi_link_pkg::ST_IGN] = 1'b1;
              next_resp_body = {1'b1, st, resp_body[7:0]};
            end
          end else if (!in_shift[spi_link_pkg::B_RW]) begin
            start_op = 1'b1;
          end else begin
            next_awaiting_wr = 1'b1;
            next_wr_addr = a;
            next_resp_body = in_shift[15:2];
          end
        end
      end
    end

    if (start_op) begin
      if (!addr_ok(a, secured)) begin
        st[spi_link_pkg::ST_BUS] = 1'b1;
        st[spi_link_pkg::ST_IGN] = start_we;
        next_resp_body = {start_we, st, resp_body[7:0]};
      end else begin
        next_state = S_REQ;
        next_op_we = start_we;
        next_op_addr = a;
        next_op_data = start_data;
        next_wait_cnt = 8'h00;
        next_bus_req = 1'b1;
        next_cpu_stall = 1'b1;
      end
    end

    // internal bus access
    unique case (state)
      S_IDLE: begin
      end
      S_REQ: begin
        if (bus_gnt) begin
          next_state = S_ACC;
          next_bus_we = op_we;
          next_bus_re = ~op_we;
          next_bus_addr = {spi_link_pkg::ADDR_PAD, op_addr};
          next_bus_wdata = op_data;
        end else if (wait_cnt == 8'(BUS_WAIT - 1)) begin
          next_state = S_IDLE;
          next_bus_req = 1'b0;
          next_cpu_stall = 1'b0;
          st = spi_link_pkg::ST_OK;
          st[spi_link_pkg::ST_BUS] = 1'b1;
          st[spi_link_pkg::ST_IGN] = op_we;
          next_resp_body = {op_we, st, resp_body[7:0]};
        end else begin
          next_wait_cnt = wait_cnt + 8'h01;
        end
      end
      S_ACC: begin
        next_state = S_DONE;
      end
      S_DONE: begin
        next_state = S_IDLE;
        next_bus_req = 1'b0;
        next_cpu_stall = 1'b0;
        next_resp_body = {op_we, spi_link_pkg::ST_OK, op_we ? op_data : bus_rdata};
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= spi_link_pkg::SYNC_RST;
      sync2 <= spi_link_pkg::SYNC_RST;
      prev <= spi_link_pkg::SYNC_RST;
      in_shift <= 16'h0000;
      out_shift <= 16'h0000;
      bit_cnt <= 5'h00;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
      in_frame <= 1'b0;
      resp_body <= spi_link_pkg::RESP_RESET;
      awaiting_wr <= 1'b0;
      wr_addr <= 13'h0000;
      pu_cnt <= 16'h0000;
      pu_window <= 1'b1;
      link_enable_bit <= 1'b0;
      reg_rdata <= 8'h00;
      state <= S_IDLE;
      op_we <= 1'b0;
      op_addr <= 13'h0000;
      op_data <= 8'h00;
      wait_cnt <= 8'h00;
      bus_req <= 1'b0;
      bus_we <= 1'b0;
      bus_re <= 1'b0;
      bus_addr <= 16'h0000;
      bus_wdata <= 8'h00;
      cpu_stall <= 1'b0;
    end else begin
      sync1 <= {powerup_enable_pin, link.sclk, link.ss_n, link.mosi};
      sync2 <= next_sync2;
      prev <= next_prev;
      in_shift <= next_in_shift;
      out_shift <= next_out_shift;
      bit_cnt <= next_bit_cnt;
      miso_out <= next_miso_out;
      miso_oe <= next_miso_oe;
      in_frame <= next_in_frame;
      resp_body <= next_resp_body;
      awaiting_wr <= next_awaiting_wr;
      wr_addr <= next_wr_addr;
      pu_cnt <= next_pu_cnt;
      pu_window <= next_pu_window;
      link_enable_bit <= next_link_enable_bit;
      reg_rdata <= next_reg_rdata;
      state <= next_state;
      op_we <= next_op_we;
      op_addr <= next_op_addr;
      op_data <= next_op_data;
      wait_cnt <= next_wait_cnt;
      bus_req <= next_bus_req;
      bus_we <= next_bus_we;
      bus_re <= next_bus_re;
      bus_addr <= next_bus_addr;
      bus_wdata <= next_bus_wdata;
      cpu_stall <= next_cpu_stall;
    end
  end

endmodule : spi_client_port
`default_nettype wire

//--- pkg/spi_link_pkg.sv
/*
  Shared constants, frame layout and parity helper for the serial client
  port and its host controller.
  Assumes a 10 MHz system clock on both ends.
*/
package spi_link_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int T_SPI_EN_US = 100;
  localparam int T_SPI_EN_CYC = (T_SPI_EN_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                T_SPI_EN_US * (CLK_HZ / 1_000_000);
  localparam int BUS_WAIT_CYC = 8;
  localparam int SCLK_HALF_CYC = 8;
  localparam int FRAME_GAP_CYC = 32;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] CNT_FULL = 5'h10;
  localparam logic [4:0] CNT_SAT = 5'h11;
  localparam logic [3:0] HOST_LAST_BIT = 4'hf;
  localparam int B_RW = 15;
  localparam int A_HI = 14;
  localparam int A_LO = 2;
  localparam int D_HI = 9;
  localparam int D_LO = 2;
  localparam int P_HI = 1;
  localparam int P_LO = 0;

  // status field bit positions
  localparam int ST_BUS = 0;
  localparam int ST_PAR = 1;
  localparam int ST_CLK = 2;
  localparam int ST_IGN = 3;
  localparam int ST_RSV = 4;
  localparam logic [4:0] ST_OK = 5'h00;

  // first response after reset: read form, ignore flag set
  localparam logic [13:0] RESP_RESET = 14'h0800;

  // ---------------------------------------------------------------
  // memory map
  // ---------------------------------------------------------------
  localparam logic [15:0] ENABLE_REG_ADDR = 16'h1802;
  localparam int ENABLE_BIT = 0;
  localparam logic [12:0] SECURE_LO_END = 13'h008f;
  localparam logic [12:0] SECURE_HI_START = 13'h1800;
  localparam logic [12:0] SECURE_HI_END = 13'h188f;
  localparam logic [1:0] SECURE_OPEN = 2'h0;
  localparam logic [2:0] ADDR_PAD = 3'h0;

  // host controller register offsets
  localparam logic [1:0] HREG_TX = 2'h0;
  localparam logic [1:0] HREG_RX = 2'h1;
  localparam logic [1:0] HREG_STAT = 2'h2;

  // sync vector reset {powerup pin, sclk, ss_n, mosi}
  // pin bit resets low so the power-up window is not closed by a stale level
  localparam logic [3:0] SYNC_RST = 4'h2;

  // even parity over b15:9 and b8:2 of a frame body b15:2
  function automatic logic [1:0] frame_parity(input logic [13:0] body);
    return {^body[13:7], ^body[6:0]};
  endfunction : frame_parity

endpackage : spi_link_pkg

//--- pkg/spi_link_if.sv
/*
  Four-wire serial link between the host controller and the client port.
  The client output is resolved here from its drive enable; undriven reads 0.
*/
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso_out;
  logic miso_oe;
  logic miso;

  assign miso = miso_oe & miso_out;

  modport device (input sclk, input ss_n, input mosi, output miso_out, output miso_oe);
  modport host (output sclk, output ss_n, output mosi, input miso);
endinterface : spi_link_if
`default_nettype wire

//--- core/spi_host_ctrl.sv
/*
  Host end of the serial link: sends one 16-bit frame per software order
  and keeps the frame received in return.
  Assumes the client samples the link through a short synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_host_ctrl #(
  parameter int HALF = spi_link_pkg::SCLK_HALF_CYC,
  parameter int GAP = spi_link_pkg::FRAME_GAP_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  spi_link_if.host link,
  // command port
  input wire logic [1:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  output logic [15:0] cmd_rdata
);

  typedef enum logic [5:0] {
    H_IDLE = 6'b000001,
    H_LEAD = 6'b000010,
    H_HIGH = 6'b000100,
    H_LOW = 6'b001000,
    H_TAIL = 6'b010000,
    H_GAP = 6'b100000
  } host_state_t;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  host_state_t state, next_state;
  logic miso_s1, miso_s2;
  logic sclk, ss_n, mosi, next_sclk, next_ss_n, next_mosi;
  logic [15:0] tx_shift, rx_shift, rx_word, next_tx_shift, next_rx_shift, next_rx_word;
  logic [7:0] div_cnt, next_div_cnt;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic done, par_ok, next_done, next_par_ok;
  logic [15:0] next_cmd_rdata;

  assign link.sclk = sclk;
  assign link.ss_n = ss_n;
  assign link.mosi = mosi;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic half_done;
    half_done = div_cnt == 8'(HALF - 1);
    next_state = state;
    next_sclk = sclk;
    next_ss_n = ss_n;
    next_mosi = mosi;
    next_tx_shift = tx_shift;
    next_rx_shift = rx_shift;
    next_rx_word = rx_word;
    next_div_cnt = div_cnt + 8'h01;
    next_bit_cnt = bit_cnt;
    next_par_ok = par_ok;
    next_done = done;
    next_cmd_rdata = 16'h0000;

    if (cmd_rd) begin
      unique case (cmd_addr)
        spi_link_pkg::HREG_RX: next_cmd_rdata = rx_word;
        spi_link_pkg::HREG_STAT: begin
          next_cmd_rdata = {13'h0000, par_ok, done, state != H_IDLE};
          next_done = 1'b0;
        end
        default: next_cmd_rdata = 16'h0000;
      endcase
    end

    unique case (state)
      H_IDLE: begin
        next_div_cnt = 8'h00;
        if (cmd_wr && cmd_addr == spi_link_pkg::HREG_TX) begin
          next_tx_shift = {cmd_wdata[13:0], spi_link_pkg::frame_parity(cmd_wdata[13:0])};
          next_mosi = cmd_wdata[13];
          next_ss_n = 1'b0;
          next_bit_cnt = 4'h0;
          next_state = H_LEAD;
        end
      end
      H_LEAD, H_LOW: begin
        if (half_done) begin
          next_sclk = 1'b1;
          next_rx_shift = {rx_shift[14:0], miso_s2};
          next_div_cnt = 8'h00;
          next_state = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          next_sclk = 1'b0;
          next_div_cnt = 8'h00;
          if (bit_cnt == spi_link_pkg::HOST_LAST_BIT) begin
            next_state = H_TAIL;
          end else begin
            next_bit_cnt = bit_cnt + 4'h1;
            next_tx_shift = {tx_shift[14:0], 1'b0};
            next_mosi = tx_shift[14];
            next_state = H_LOW;
          end
        end
      end
      H_TAIL: begin
        if (half_done) begin
          next_ss_n = 1'b1;
          next_rx_word = rx_shift;
          next_par_ok = spi_link_pkg::frame_parity(rx_shift[15:2]) ==
                        rx_shift[spi_link_pkg::P_HI:spi_link_pkg::P_LO];
          next_done = 1'b1;
          next_div_cnt = 8'h00;
          next_state = H_GAP;
        end
      end
      H_GAP: begin
        if (div_cnt == 8'(GAP - 1)) begin
          next_state = H_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      sclk <= 1'b0;
      ss_n <= 1'b1;
      mosi <= 1'b0;
      tx_shift <= 16'h0000;
      rx_shift <= 16'h0000;
      rx_word <= 16'h0000;
      div_cnt <= 8'h00;
      bit_cnt <= 4'h0;
      done <= 1'b0;
      par_ok <= 1'b0;
      cmd_rdata <= 16'h0000;
    end else begin
      state <= next_state;
      miso_s1 <= link.miso;
      miso_s2 <= miso_s1;
      sclk <= next_sclk;
      ss_n <= next_ss_n;
      mosi <= next_mosi;
      tx_shift <= next_tx_shift;
      rx_shift <= next_rx_shift;
      rx_word <= next_rx_word;
      div_cnt <= next_div_cnt;
      bit_cnt <= next_bit_cnt;
      done <= next_done;
      par_ok <= next_par_ok;
      cmd_rdata <= next_cmd_rdata;
    end
  end

endmodule : spi_host_ctrl
`default_nettype wire

//--- test/spi_client_bus_host_chk.sv
/*
  Link checker: watches the four wires between host end and client end.
  Assumes a host half period of 8 clocks and an enabled client port.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_link_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // link wires
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic miso
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic sclk_q;
  logic ss_q;
  logic [4:0] n_rise;
  logic [4:0] next_n_rise;
  logic [15:0] mi_sh;
  logic [15:0] next_mi_sh;
  logic [15:0] mo_sh;
  logic [15:0] next_mo_sh;
  // ------------
  // frame capture
  // ------------
  always_comb begin
    next_n_rise = n_rise;
    next_mi_sh = mi_sh;
    next_mo_sh = mo_sh;
    if (ss_n && ss_q) begin
      next_n_rise = 5'h00;
    end else if (sclk && !sclk_q) begin
      next_n_rise = n_rise + 5'h01;
      next_mi_sh = {mi_sh[14:0], miso};
      next_mo_sh = {mo_sh[14:0], mosi};
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q <= 1'b0;
      ss_q <= 1'b1;
      n_rise <= 5'h00;
      mi_sh <= 16'h0000;
      mo_sh <= 16'h0000;
    end else begin
      sclk_q <= sclk;
      ss_q <= ss_n;
      n_rise <= next_n_rise;
      mi_sh <= next_mi_sh;
      mo_sh <= next_mo_sh;
    end
  end
  // ------------
  // properties
  // ------------
  sequence s_lead;
    !sclk [*8] ##1 sclk;
  endsequence
  sequence s_high;
    sclk [*8] ##1 !sclk;
  endsequence
  AST_IDLE_LOW: assert property (ss_n |-> !sclk)
    else $error("sclk high outside frame");
  AST_LEAD: assert property ($fell(ss_n) |-> s_lead)
    else $error("first sclk rise misplaced");
  AST_HIGH: assert property ($rose(sclk) |-> s_high)
    else $error("sclk high phase wrong");
  AST_MOSI_HOLD: assert property ($rose(sclk) |-> $stable(mosi) [*8])
    else $error("mosi moved while sclk high");
  AST_MISO_HOLD: assert property ($rose(sclk) |-> $stable(miso_out))
    else $error("miso moved at sclk rise");
  AST_LEN: assert property ($rose(ss_n) |-> n_rise == 5'h10)
    else $error("frame not 16 clocks");
  AST_MOSI_PAR: assert property ($rose(ss_n) |-> mo_sh[1:0] == {^mo_sh[15:9], ^mo_sh[8:2]})
    else $error("host parity wrong");
  AST_MISO_PAR: assert property ($rose(ss_n) |-> mi_sh[1:0] == {^mi_sh[15:9], ^mi_sh[8:2]})
    else $error("client parity wrong");
  AST_RSV: assert property ($rose(ss_n) && !mi_sh[15] |-> !mi_sh[14])
    else $error("reserved status bit set");
  AST_OE_ON: assert property ($fell(ss_n) |-> ##[1:6] miso_oe)
    else $error("client did not drive");
  AST_OE_OFF: assert property (ss_n [*6] |-> !miso_oe)
    else $error("client drives outside frame");
endmodule : spi_link_chk
`default_nettype wire

//--- test/spi_client_bus_host_tb_top.sv
/*
  Bench joining host end and client port; models the internal bus here.
  Assumes the host end builds every frame and its parity.
*/
`timescale 1ns/1ps
`default_nettype none
module spi_client_bus_host_tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic powerup_enable_pin = 1'b0;
  logic [1:0] security_level_field = 2'h0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic bus_req, bus_we, bus_re, cpu_stall;
  logic bus_gnt = 1'b0;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic [7:0] bus_rdata = 8'h00;
  logic [1:0] cmd_addr = 2'h0;
  logic [15:0] cmd_wdata = 16'h0000;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [15:0] cmd_rdata;
  logic rx_v = 1'b0;
  logic rg_v = 1'b0;
  logic [7:0] mem [0:8191];
  logic [31:0] q [$];
  logic [12:0] a1, a2, a3, a4;
  logic [7:0] dw;
  int n_errors = 0;
  int n_checks = 0;
  int gdly = 0;
  int gcnt = 0;
  spi_link_if link_i ();
  spi_client_port #(.EN_CYC(20)) spi_client_port_i (.clk_sys, .rst_n, .link(link_i),
    .powerup_enable_pin, .stop_mode(1'b0), .security_level_field, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .link_enable_bit(), .bus_req, .bus_gnt, .bus_addr,
    .bus_wdata, .bus_we, .bus_re, .bus_rdata, .cpu_stall);
  spi_host_ctrl spi_host_ctrl_i (.clk_sys, .rst_n, .link(link_i), .cmd_addr, .cmd_wdata,
    .cmd_wr, .cmd_rd, .cmd_rdata);
  spi_link_chk spi_link_chk_i (.clk_sys, .rst_n, .sclk(link_i.sclk), .ss_n(link_i.ss_n),
    .mosi(link_i.mosi), .miso_out(link_i.miso_out), .miso_oe(link_i.miso_oe),
    .miso(link_i.miso));
  always #50 clk_sys = ~clk_sys;
  // ------------
  // bus model and result monitor
  // ------------
  always @(posedge clk_sys) begin
    gcnt <= bus_req ? gcnt + 1 : 0;
    bus_gnt <= bus_req && gcnt >= gdly;
    bus_rdata <= bus_re ? mem[bus_addr[12:0]] : ~bus_rdata;
    if (bus_we) mem[bus_addr[12:0]] <= bus_wdata;
    rx_v <= cmd_rd && cmd_addr == spi_link_pkg::HREG_RX;
    rg_v <= reg_rd;
    n_checks++;
    if (cpu_stall !== bus_req) begin
      n_errors++;
      $display("[FAIL] %0t stall %h req %h", $time, cpu_stall, bus_req);
    end
  end
  always @(negedge clk_sys) begin
    if (rx_v) chk(cmd_rdata);
    if (rg_v) chk({8'h00, reg_rdata});
  end
  function automatic logic [15:0] fr(input logic [13:0] b);
    return {b, ^b[13:7], ^b[6:0]};
  endfunction : fr
  task automatic chk(input logic [15:0] got);
    logic [31:0] e;
    e = (q.size() > 0) ? q.pop_front() : {16'hffff, ~got};
    n_checks++;
    if ((got & e[31:16]) !== (e[15:0] & e[31:16])) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, e[15:0]);
    end
  endtask : chk
  task automatic rg(input logic [15:0] a, input logic [7:0] v, input logic wr);
    if (!wr) q.push_back({16'hffff, 8'h00, v});
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask : rg
  task automatic hcmd(input logic [1:0] a, input logic [15:0] w, input logic rd);
    @(posedge clk_sys);
    cmd_addr <= a;
    cmd_wdata <= w;
    cmd_wr <= !rd;
    cmd_rd <= rd;
    @(posedge clk_sys);
    cmd_wr <= 1'b0;
    cmd_rd <= 1'b0;
  endtask : hcmd
  // one frame out, its returned frame checked against e under mask m
  task automatic xfer(input logic [13:0] b, input logic [15:0] m, input logic [13:0] e);
    logic dn;
    int i;
    dn = 1'b0;
    q.push_back({m, fr(e)});
    hcmd(spi_link_pkg::HREG_TX, {2'b00, b}, 1'b0);
    for (i = 0; i < 400; i++) begin
      hcmd(spi_link_pkg::HREG_STAT, 16'h0000, 1'b1);
      #1;
      dn = dn | (cmd_rdata[1] === 1'b1);
      if (dn && cmd_rdata[0] === 1'b0) break;
    end
    if (i == 400) begin
      n_errors++;
      results();
    end else begin
      hcmd(spi_link_pkg::HREG_RX, 16'h0000, 1'b1);
    end
  endtask : xfer
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results
  // ------------
  // sequence
  // ------------
  initial begin
    void'($urandom(32'h6cab_83d3));
    for (int k = 0; k < 8192; k++) mem[k] = 8'($urandom());
    a1 = 13'($urandom_range(1023, 0));
    a2 = 13'($urandom_range(2047, 1024));
    a3 = 13'($urandom_range(3071, 2048));
    a4 = 13'($urandom_range(4095, 3072));
    dw = 8'($urandom());
    gdly = $urandom_range(3, 0);
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk_sys);
    powerup_enable_pin <= 1'b1;
    rg(spi_link_pkg::ENABLE_REG_ADDR, 8'h01, 1'b0);
    rg(spi_link_pkg::ENABLE_REG_ADDR, 8'h00, 1'b1);
    rg(spi_link_pkg::ENABLE_REG_ADDR, 8'h00, 1'b0);
    rg(spi_link_pkg::ENABLE_REG_ADDR, 8'h01, 1'b1);
    rg(spi_link_pkg::ENABLE_REG_ADDR, 8'h01, 1'b0);
    rg(16'h1803, 8'h00, 1'b0);
    $display("enable test done");
    xfer({1'b0, a1}, 16'hffff, 14'h0800);
    xfer({1'b0, a2}, 16'hffff, {6'h00, mem[a1]});
    xfer({1'b1, a3}, 16'hffff, {6'h00, mem[a2]});
    xfer({1'b1, 5'h15, dw}, 16'hffff, {1'b1, a3});
    xfer({1'b0, a3}, 16'hffff, {6'h20, dw});
    security_level_field <= 2'h1;
    xfer({1'b0, 13'h0100}, 16'hffff, {6'h00, dw});
    $display("transfer test done");
    xfer({1'b0, 13'h1810}, 16'h7c00, 14'h0100);
    security_level_field <= 2'h0;
    gdly = 20;
    xfer({1'b0, a1}, 16'hffff, {6'h00, mem[13'h1810]});
    gdly = $urandom_range(3, 0);
    xfer({1'b1, a4}, 16'h7c00, 14'h0100);
    xfer({1'b0, 5'h0a, dw}, 16'hffff, {1'b1, a4});
    xfer({1'b0, a4}, 16'h7c00, 14'h0800);
    xfer({1'b0, a1}, 16'hffff, {6'h00, mem[a4]});
    $display("fault test done");
    results();
  end
endmodule : spi_client_bus_host_tb_top
`default_nettype wire
